//--- logic/rsd_defines.svh
// offsets, field positions, reset values and timing counts of the sequence-delay block
`ifndef RSD_DEFINES_SVH
`define RSD_DEFINES_SVH

// register offsets
`define RSD_OFF_RAIL_B_DELAY 8'h0a
`define RSD_OFF_STEP_UP_DELAY 8'h0b
`define RSD_OFF_OUT_A_DELAY 8'h0c
`define RSD_OFF_OUT_B_DELAY 8'h0d
`define RSD_OFF_OUT_C_DELAY 8'h0e
`define RSD_OFF_DRIVE_CTRL 8'h0f
`define RSD_OFF_SEQ_STATUS 8'h20

// reset values
`define RSD_RST_DELAY 8'h00
`define RSD_RST_DRIVE 8'haa

// delay register fields
`define RSD_OFF_CODE_HI 7
`define RSD_OFF_CODE_LO 4
`define RSD_ON_CODE_HI 3
`define RSD_ON_CODE_LO 0

// drive control fields, relative to the output's nibble
`define RSD_DRV_LEVEL 0
`define RSD_DRV_GATE_LO 1
`define RSD_DRV_GATE_HI 2
`define RSD_DRV_DRAIN 3
`define RSD_DRV_NIBBLE_W 4

// gating field values
`define RSD_GATE_NONE 2'h0
`define RSD_GATE_EN1 2'h1
`define RSD_GATE_EN2 2'h2
`define RSD_GATE_EN3 2'h3

// channel indices, also offset minus the first delay offset
`define RSD_NCHAN 5
`define RSD_CH_RAIL_B 0
`define RSD_CH_STEP_UP 1
`define RSD_CH_OUT_A 2
`define RSD_CH_OUT_B 3
`define RSD_CH_OUT_C 4
`define RSD_NDRIVE 2

// timing: one code step is 0.5 ms, the wide range doubles it
`define RSD_STEP_US 500
`define RSD_CLK_PERIOD_NS 4
`define RSD_STEP_CYC ((`RSD_STEP_US * 1000) / `RSD_CLK_PERIOD_NS)

`endif

//--- logic/rsd_pkg.sv
// types shared by the sequence-delay block
package rsd_pkg;
	typedef logic [7:0] rsd_byte_t;
	typedef logic [3:0] rsd_code_t;
	typedef logic [4:0] rsd_steps_t;
	typedef enum logic [1:0] {
		RSD_ST_OFF,
		RSD_ST_WAIT_ON,
		RSD_ST_ON,
		RSD_ST_WAIT_OFF
	} rsd_chan_state_e;
endpackage

//--- logic/rsd_if.sv
// carriers between the top and the per-channel delay and drive modules
`timescale 1ns/1ps
`default_nettype none

// one sequenced channel
interface rsd_seq_if;
	logic ctrl;
	rsd_pkg::rsd_code_t on_code;
	rsd_pkg::rsd_code_t off_code;
	logic range_sel;
	logic tick;
	logic active;
	modport ctl (output ctrl, output on_code, output off_code, output range_sel,
		output tick, input active);
	modport chan (input ctrl, input on_code, input off_code, input range_sel,
		input tick, output active);
endinterface

// one general-purpose output pin
interface rsd_drive_if;
	logic level;
	logic [1:0] gate;
	logic [3:1] en_pins;
	logic drain_sel;
	logic delayed;
	logic bypass;
	logic bypass_level;
	logic gated;
	logic pin_o;
	logic pin_oe;
	modport ctl (output level, output gate, output en_pins, output drain_sel,
		output delayed, output bypass, output bypass_level,
		input gated, input pin_o, input pin_oe);
	modport drv (input level, input gate, input en_pins, input drain_sel,
		input delayed, input bypass, input bypass_level,
		output gated, output pin_o, output pin_oe);
endinterface

`default_nettype wire

//--- logic/rsd_delay_chan.sv
// start-up and shutdown delay timer for one sequenced channel
`timescale 1ns/1ps
`default_nettype none

module rsd_delay_chan (
	input wire logic mclk,
	input wire logic rst,
	rsd_seq_if.chan seq
);
	rsd_pkg::rsd_chan_state_e state_reg;
	rsd_pkg::rsd_steps_t count_reg;
	rsd_pkg::rsd_steps_t on_steps;
	rsd_pkg::rsd_steps_t off_steps;

	// one tick is one code step; wide range counts two per code
	assign on_steps = seq.range_sel ? {seq.on_code, 1'b0} : {1'b0, seq.on_code};
	assign off_steps = seq.range_sel ? {seq.off_code, 1'b0} : {1'b0, seq.off_code};

	// sequencing state and delay count
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_reg <= rsd_pkg::RSD_ST_OFF;
			count_reg <= '0;
		end else begin
			unique case (state_reg)
				rsd_pkg::RSD_ST_OFF: begin
					if (seq.ctrl) begin
						// rising edge starts the on delay
						count_reg <= on_steps;
						state_reg <= (on_steps == '0) ? rsd_pkg::RSD_ST_ON
							: rsd_pkg::RSD_ST_WAIT_ON;
					end
				end
				rsd_pkg::RSD_ST_WAIT_ON: begin
					if (!seq.ctrl) begin
						state_reg <= rsd_pkg::RSD_ST_OFF;
					end else if (seq.tick) begin
						count_reg <= count_reg - 5'h01;
						if (count_reg == 5'h01) begin
							state_reg <= rsd_pkg::RSD_ST_ON;
						end
					end
				end
				rsd_pkg::RSD_ST_ON: begin
					if (!seq.ctrl) begin
						// falling edge starts the off delay, zero code acts at once
						count_reg <= off_steps;
						state_reg <= (off_steps == '0) ? rsd_pkg::RSD_ST_OFF
							: rsd_pkg::RSD_ST_WAIT_OFF;
					end
				end
				rsd_pkg::RSD_ST_WAIT_OFF: begin
					if (seq.ctrl) begin
						state_reg <= rsd_pkg::RSD_ST_ON;
					end else if (seq.tick) begin
						count_reg <= count_reg - 5'h01;
						if (count_reg == 5'h01) begin
							state_reg <= rsd_pkg::RSD_ST_OFF;
						end
					end
				end
			endcase
		end
	end

	// channel is on while on or waiting to shut down
	assign seq.active = (state_reg == rsd_pkg::RSD_ST_ON)
		|| (state_reg == rsd_pkg::RSD_ST_WAIT_OFF);
endmodule

`default_nettype wire

//--- logic/rsd_out_drive.sv
// enable-pin gating and drive type of one general-purpose output
`timescale 1ns/1ps
`default_nettype none

`include "rsd_defines.svh"

module rsd_out_drive (
	rsd_drive_if.drv d
);
	logic pin_level;

	// level bit, optionally ANDed with one enable pin
	always_comb begin
		unique case (d.gate)
			`RSD_GATE_NONE: d.gated = d.level;
			`RSD_GATE_EN1: d.gated = d.level & d.en_pins[1];
			`RSD_GATE_EN2: d.gated = d.level & d.en_pins[2];
			`RSD_GATE_EN3: d.gated = d.level & d.en_pins[3];
		endcase
	end

	// shared-pin function bypasses the sequenced level
	assign pin_level = d.bypass ? d.bypass_level : d.delayed;

	// push-pull drives both levels, open drain only pulls low
	assign d.pin_o = d.drain_sel ? 1'b0 : pin_level;
	assign d.pin_oe = d.drain_sel ? !pin_level : 1'b1;
endmodule

`default_nettype wire

//--- logic/rsd_seq_top.sv
// rail and output sequence delays with general-purpose output control
`timescale 1ns/1ps
`default_nettype none

`include "rsd_defines.svh"

module rsd_seq_top #(
	parameter int STEP_CYCLES = `RSD_STEP_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [39:0] otp_delay_defaults,
	input wire logic [7:0] otp_drive_default,
	input wire logic enable_pin_one,
	input wire logic enable_pin_two,
	input wire logic enable_pin_three,
	input wire logic startup_delay_sel,
	input wire logic rail_b_ctrl,
	input wire logic step_up_ctrl,
	input wire logic out_c_ctrl,
	input wire logic out_b_is_gpo,
	input wire logic power_good_b,
	output logic step_down_rail_b_on,
	output logic step_up_on,
	output logic general_out_c,
	output logic general_out_a_o,
	output logic general_out_a_oe,
	output logic general_out_b_o,
	output logic general_out_b_oe
);

	////////////////////////////////////////////////////////////////////////////
	// declarations

	// delay registers in channel order, offsets 0xa upward
	rsd_pkg::rsd_byte_t delay_reg [`RSD_NCHAN];
	rsd_pkg::rsd_byte_t drive_ctrl_reg;
	logic otp_load_pending_reg;
	logic [16:0] step_cnt_reg;
	logic step_tick_reg;
	logic [`RSD_NCHAN-1:0] ctrl_src;
	logic [`RSD_NCHAN-1:0] chan_active;
	logic [`RSD_NDRIVE-1:0] drv_gated;
	logic [`RSD_NDRIVE-1:0] drv_pin_o;
	logic [`RSD_NDRIVE-1:0] drv_pin_oe;
	rsd_pkg::rsd_byte_t rdata_next;
	logic [7:0] delay_index;

	rsd_seq_if seq [`RSD_NCHAN] ();
	rsd_drive_if drv [`RSD_NDRIVE] ();

	////////////////////////////////////////////////////////////////////////////
	// default store load

	// pending flag set in reset, cleared by the first cycle after release
	always_ff @(posedge mclk) begin
		if (rst) begin
			otp_load_pending_reg <= 1'b1;
		end else begin
			otp_load_pending_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register file

	// index of a delay register from its offset
	assign delay_index = reg_addr - `RSD_OFF_RAIL_B_DELAY;

	// delay registers: reset to zero, then store defaults, then host writes
	always_ff @(posedge mclk) begin
		for (int i = 0; i < `RSD_NCHAN; i++) begin
			if (rst) begin
				delay_reg[i] <= `RSD_RST_DELAY;
			end else if (otp_load_pending_reg) begin
				delay_reg[i] <= otp_delay_defaults[i*8 +: 8];
			end else if (reg_wr && (reg_addr >= `RSD_OFF_RAIL_B_DELAY)
				&& (reg_addr <= `RSD_OFF_OUT_C_DELAY)
				&& (delay_index == 8'(i))) begin
				delay_reg[i] <= reg_wdata;
			end
		end
	end

	// output drive control register
	always_ff @(posedge mclk) begin
		if (rst) begin
			drive_ctrl_reg <= `RSD_RST_DRIVE;
		end else if (otp_load_pending_reg) begin
			drive_ctrl_reg <= otp_drive_default;
		end else if (reg_wr && (reg_addr == `RSD_OFF_DRIVE_CTRL)) begin
			drive_ctrl_reg <= reg_wdata;
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rdata_next = 8'h00;
		if ((reg_addr >= `RSD_OFF_RAIL_B_DELAY) && (reg_addr <= `RSD_OFF_OUT_C_DELAY)) begin
			rdata_next = delay_reg[delay_index[2:0]];
		end else if (reg_addr == `RSD_OFF_DRIVE_CTRL) begin
			rdata_next = drive_ctrl_reg;
		end else if (reg_addr == `RSD_OFF_SEQ_STATUS) begin
			rdata_next = {3'h0, chan_active};
		end
	end

	// read data registered, one cycle after the address
	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// step time base

	// free-running divider, one-cycle tick per half-ms step
	always_ff @(posedge mclk) begin
		if (rst) begin
			step_cnt_reg <= '0;
			step_tick_reg <= 1'b0;
		end else if (step_cnt_reg == 17'(STEP_CYCLES - 1)) begin
			step_cnt_reg <= '0;
			step_tick_reg <= 1'b1;
		end else begin
			step_cnt_reg <= step_cnt_reg + 17'h00001;
			step_tick_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// control sources of the sequenced channels

	// outputs a and b are sequenced from their gated level
	always_comb begin
		ctrl_src = '0;
		ctrl_src[`RSD_CH_RAIL_B] = rail_b_ctrl;
		ctrl_src[`RSD_CH_STEP_UP] = step_up_ctrl;
		ctrl_src[`RSD_CH_OUT_A] = drv_gated[0];
		ctrl_src[`RSD_CH_OUT_B] = drv_gated[1];
		ctrl_src[`RSD_CH_OUT_C] = out_c_ctrl;
	end

	////////////////////////////////////////////////////////////////////////////
	// delay channels

	generate
		for (genvar c = 0; c < `RSD_NCHAN; c++) begin : g_chan
			// codes and range to the channel timer
			assign seq[c].ctrl = ctrl_src[c];
			assign seq[c].off_code = delay_reg[c][`RSD_OFF_CODE_HI:`RSD_OFF_CODE_LO];
			assign seq[c].on_code = delay_reg[c][`RSD_ON_CODE_HI:`RSD_ON_CODE_LO];
			assign seq[c].range_sel = startup_delay_sel;
			assign seq[c].tick = step_tick_reg;
			assign chan_active[c] = seq[c].active;

			rsd_delay_chan u_chan (
				.mclk(mclk),
				.rst(rst),
				.seq(seq[c])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// general-purpose output drive

	generate
		for (genvar d = 0; d < `RSD_NDRIVE; d++) begin : g_drive
			localparam int BASE = d * `RSD_DRV_NIBBLE_W;
			// level bit 0 for a, bit 4 for b
			assign drv[d].level = drive_ctrl_reg[BASE + `RSD_DRV_LEVEL];
			// gating field bits 2-1 for a, 6-5 for b
			assign drv[d].gate = drive_ctrl_reg[BASE + `RSD_DRV_GATE_HI:
				BASE + `RSD_DRV_GATE_LO];
			// drain select bit 3 for a, 7 for b
			assign drv[d].drain_sel = drive_ctrl_reg[BASE + `RSD_DRV_DRAIN];
			assign drv[d].en_pins = {enable_pin_three, enable_pin_two, enable_pin_one};
			assign drv[d].delayed = chan_active[`RSD_CH_OUT_A + d];
			assign drv_gated[d] = drv[d].gated;
			assign drv_pin_o[d] = drv[d].pin_o;
			assign drv_pin_oe[d] = drv[d].pin_oe;

			rsd_out_drive u_drive (
				.d(drv[d])
			);
		end
	endgenerate

	// output a has no shared function
	assign drv[0].bypass = 1'b0;
	assign drv[0].bypass_level = 1'b0;

	// output b shows power-good unless set to general output
	assign drv[1].bypass = !out_b_is_gpo;
	assign drv[1].bypass_level = power_good_b;

	////////////////////////////////////////////////////////////////////////////
	// registered outputs

	// rail enables and plain output c
	always_ff @(posedge mclk) begin
		if (rst) begin
			step_down_rail_b_on <= 1'b0;
			step_up_on <= 1'b0;
			general_out_c <= 1'b0;
		end else begin
			step_down_rail_b_on <= chan_active[`RSD_CH_RAIL_B];
			step_up_on <= chan_active[`RSD_CH_STEP_UP];
			general_out_c <= chan_active[`RSD_CH_OUT_C];
		end
	end

	// pin drive of outputs a and b; reset leaves both pins released
	always_ff @(posedge mclk) begin
		if (rst) begin
			general_out_a_o <= 1'b0;
			general_out_a_oe <= 1'b0;
			general_out_b_o <= 1'b0;
			general_out_b_oe <= 1'b0;
		end else begin
			general_out_a_o <= drv_pin_o[0];
			general_out_a_oe <= drv_pin_oe[0];
			general_out_b_o <= drv_pin_o[1];
			general_out_b_oe <= drv_pin_oe[1];
		end
	end

endmodule

`default_nettype wire

//--- dv/rsd_seq_checker.sv
// concurrent checks of the sequence-delay block at its top ports
`timescale 1ns/1ps
`default_nettype none

module rsd_seq_checker #(
	parameter int STEP_CYCLES = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [39:0] otp_delay_defaults,
	input wire logic [7:0] otp_drive_default,
	input wire logic rail_b_ctrl,
	input wire logic step_up_ctrl,
	input wire logic out_b_is_gpo,
	input wire logic power_good_b,
	input wire logic step_down_rail_b_on,
	input wire logic step_up_on,
	input wire logic general_out_a_o,
	input wire logic general_out_a_oe,
	input wire logic general_out_b_oe
);
	logic [4:0][7:0] dly_q;
	logic [7:0] drv_q;
	logic ld_q;
	logic [7:0] exp_rd;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	////////////////////////////////////////
	// shadow of the writable registers, loaded from the default store
	always_ff @(posedge mclk) begin
		if (rst) begin
			dly_q <= '0;
			drv_q <= 8'haa;
			ld_q <= 1'b1;
		end else begin
			ld_q <= 1'b0;
			if (ld_q) begin
				dly_q <= otp_delay_defaults;
				drv_q <= otp_drive_default;
			end else if (reg_wr && reg_addr == 8'h0f) begin
				drv_q <= reg_wdata;
			end else if (reg_wr && reg_addr >= 8'h0a && reg_addr <= 8'h0e) begin
				dly_q[reg_addr[2:0] - 3'h2] <= reg_wdata;
			end
		end
	end

	// read value expected for the current offset
	always_comb begin
		exp_rd = 8'h00;
		if (reg_addr == 8'h0f) exp_rd = drv_q;
		if (reg_addr >= 8'h0a && reg_addr <= 8'h0e) exp_rd = dly_q[reg_addr[2:0] - 3'h2];
	end

	////////////////////////////////////////
	sequence s_rb_rise;
		$rose(rail_b_ctrl) && dly_q[0][3:0] == 4'h0 ##1 rail_b_ctrl;
	endsequence
	sequence s_su_fall;
		$fell(step_up_ctrl) && dly_q[1][7:4] == 4'h0 ##1 !step_up_ctrl;
	endsequence
	sequence s_su_blip;
		$rose(step_up_ctrl) && dly_q[1][3:1] != 3'h0 && !step_up_on ##1 !step_up_ctrl;
	endsequence
	property p_rel;
		$fell(rst) |-> !step_down_rail_b_on && !step_up_on && !general_out_a_oe && !general_out_b_oe;
	endproperty
	property p_rb_on;
		s_rb_rise |=> step_down_rail_b_on;
	endproperty
	property p_su_off;
		s_su_fall |=> !step_up_on;
	endproperty
	property p_abandon;
		s_su_blip |-> ##1 !step_up_on [*3];
	endproperty
	property p_rd;
		!$past(rst) && $past(reg_addr) != 8'h20 |-> reg_rdata == $past(exp_rd);
	endproperty
	property p_a_od;
		$past(drv_q[3]) && !$past(rst) |-> !general_out_a_o;
	endproperty
	property p_a_pp;
		!$past(drv_q[3]) && !$past(rst) && !$past(rst, 2) |-> general_out_a_oe;
	endproperty
	property p_pg;
		$past(!out_b_is_gpo && drv_q[7]) && !$past(rst) |-> general_out_b_oe == !$past(power_good_b);
	endproperty
	a_rel: assert property (p_rel) else $error("outputs not idle after reset");
	a_rb_on: assert property (p_rb_on) else $error("rail b late with code 0");
	a_su_off: assert property (p_su_off) else $error("step-up late off");
	a_abandon: assert property (p_abandon) else $error("pending start kept");
	a_rd: assert property (p_rd) else $error("read data wrong");
	a_a_od: assert property (p_a_od) else $error("out a drives high");
	a_a_pp: assert property (p_a_pp) else $error("out a not driven");
	a_pg: assert property (p_pg) else $error("power good not shown");
endmodule

bind rsd_seq_top rsd_seq_checker #(.STEP_CYCLES(STEP_CYCLES)) i_chk (.mclk(mclk), .rst(rst),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.otp_delay_defaults(otp_delay_defaults), .otp_drive_default(otp_drive_default),
	.rail_b_ctrl(rail_b_ctrl), .step_up_ctrl(step_up_ctrl), .out_b_is_gpo(out_b_is_gpo),
	.power_good_b(power_good_b), .step_down_rail_b_on(step_down_rail_b_on),
	.step_up_on(step_up_on), .general_out_a_o(general_out_a_o),
	.general_out_a_oe(general_out_a_oe), .general_out_b_oe(general_out_b_oe));

`default_nettype wire

//--- dv/rsd_host_model.sv
// host side: register writes and reads, enable pins
`timescale 1ns/1ps
`default_nettype none

module rsd_host_model (
	input wire logic mclk,
	input wire logic [7:0] reg_rdata,
	output logic reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic [3:1] en_pins
);
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		en_pins = 3'h0;
	end

	// one-cycle strobe, data scrambled once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask

	// registered read: data one edge after the offset
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		@(negedge mclk);
		d = reg_rdata;
	endtask
endmodule

`default_nettype wire

//--- dv/tb_rail_and_output_sequence_delays.sv
// self-checking bench of the sequence-delay block
`timescale 1ns/1ps
`default_nettype none

module tb_rail_and_output_sequence_delays;
	localparam int S = 8;
	logic mclk, rst, sel, rb_c, su_c, oc_c, is_gpo, pg, wr;
	logic rb_on, su_on, oc_on, a_o, a_oe, b_o, b_oe;
	logic [39:0] otp_d;
	logic [7:0] otp_v, rdata, addr, wdata, v, w, drv;
	logic [3:1] en;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	int t, k;
	integer seed = 55168;

	rsd_host_model i_host (.mclk(mclk), .reg_rdata(rdata), .reg_wr(wr), .reg_addr(addr),
		.reg_wdata(wdata), .en_pins(en));
	rsd_seq_top #(.STEP_CYCLES(S)) i_dut (.mclk(mclk), .rst(rst), .reg_wr(wr),
		.reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .otp_delay_defaults(otp_d),
		.otp_drive_default(otp_v), .enable_pin_one(en[1]), .enable_pin_two(en[2]),
		.enable_pin_three(en[3]), .startup_delay_sel(sel), .rail_b_ctrl(rb_c),
		.step_up_ctrl(su_c), .out_c_ctrl(oc_c), .out_b_is_gpo(is_gpo), .power_good_b(pg),
		.step_down_rail_b_on(rb_on), .step_up_on(su_on), .general_out_c(oc_on),
		.general_out_a_o(a_o), .general_out_a_oe(a_oe), .general_out_b_o(b_o),
		.general_out_b_oe(b_oe));

	////////////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		if (n_mismatch == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// reset with a fresh default image, then read it back
	task automatic do_reset;
		rst = 1'b1;
		{rb_c, su_c, oc_c} = 3'h0;
		otp_d = {8'($random(seed)), 32'($random(seed))};
		otp_v = 8'($random(seed));
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		for (int i = 0; i < 5; i++) begin
			i_host.rd(8'h0a + 8'(i), v);
			check(v, otp_d[8 * i +: 8]);
		end
		i_host.rd(8'h0f, v);
		check(v, otp_v);
	endtask

	task automatic set_ctrl(input int c, input logic x);
		case (c)
			0: rb_c = x;
			1: su_c = x;
			2: i_host.wr(8'h0f, {7'h00, x});
			3: i_host.wr(8'h0f, {3'h0, x, 4'h0});
			default: oc_c = x;
		endcase
	endtask

	function automatic logic outv(input int c);
		case (c)
			0: return rb_on;
			1: return su_on;
			2: return a_o;
			3: return b_o;
			default: return oc_on;
		endcase
	endfunction

	// toggle a channel and time its output against the code
	task automatic timed(input int c, input logic x, input int code);
		k = code * (sel ? 2 : 1);
		set_ctrl(c, x);
		t = 0;
		while (outv(c) !== x && t < 40 * S) begin
			@(negedge mclk);
			t++;
		end
		check({7'h00, t >= (k - 1) * S + 2 && t <= k * S + 4}, 8'h01);
	endtask

	// expected pin value and enable of one output
	function automatic logic [1:0] pin(input logic [3:0] f, input logic gpo);
		logic x;
		x = gpo ? f[0] && (f[2:1] == 2'h0 || en[f[2:1]]) : pg;
		return f[3] ? {1'b0, !x} : {x, 1'b1};
	endfunction

	// short reversal of the step-up control, output must not move
	task automatic blip(input logic x);
		su_c = x;
		@(negedge mclk);
		su_c = !x;
		t = 0;
		repeat (6 * S) begin
			@(negedge mclk);
			if (su_on !== !x) t++;
		end
		check(8'(t), 8'h00);
	endtask

	////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 20000) begin
			n_mismatch++;
			final_report();
		end
	end

	initial begin
		sel = 1'b0;
		is_gpo = 1'b0;
		pg = 1'b0;
		do_reset();
		// every writable offset and unmapped neighbours
		for (int i = 9; i < 17; i++) begin
			v = 8'($random(seed));
			i_host.wr(8'(i), v);
			i_host.rd(8'(i), w);
			check(w, (i > 9 && i < 16) ? v : 8'h00);
		end
		// settle outputs a and b low and push-pull before timing them
		is_gpo = 1'b1;
		i_host.wr(8'h0f, 8'h00);
		repeat (40 * S) @(negedge mclk);
		// start-up and shutdown delays, both step ranges
		for (int c = 0; c < 5; c++) begin
			for (int s = 0; s < 2; s++) begin
				sel = s[0];
				v = 8'($random(seed));
				if (c < 2) v = s ? 8'hf0 : 8'h0f;
				i_host.wr(8'h0a + 8'(c), v);
				timed(c, 1'b1, v[3:0]);
				timed(c, 0, v[7:4]);
			end
		end
		// gating and drive type with random settings
		i_host.wr(8'h0c, 8'h00);
		i_host.wr(8'h0d, 8'h00);
		for (int n = 0; n < 40; n++) begin
			drv = 8'($random(seed));
			{pg, is_gpo} = 2'($random(seed));
			i_host.en_pins = 3'($random(seed));
			i_host.wr(8'h0f, drv);
			repeat (6) @(negedge mclk);
			check({6'h00, a_o, a_oe}, {6'h00, pin(drv[3:0], 1'b1)});
			check({6'h00, b_o, b_oe}, {6'h00, pin(drv[7:4], is_gpo)});
		end
		// abandoned start-up and shutdown
		sel = 1'b0;
		i_host.wr(8'h0b, 8'h44);
		blip(1'b1);
		su_c = 1'b1;
		repeat (6 * S) @(negedge mclk);
		check({7'h00, su_on}, 8'h01);
		blip(1'b0);
		do_reset();
		final_report();
	end
endmodule

`default_nettype wire
